// ### logic/sckp_pkg.sv
// Constants, codes and state type of the power-state block
package sckp_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0]  REG_CTRL       = 4'h0;
	localparam logic [3:0]  REG_STATUS     = 4'h4;
	localparam logic [3:0]  REG_ERR        = 4'h8;
	localparam int          CTRL_ODT_EN    = 0;
	localparam int          CTRL_SLOW_EXIT = 1;
	localparam int          CTRL_WR_LSB    = 2;
	localparam logic [4:0]  CTRL_RESET     = 5'h04;
	localparam int          ST_STATE_LSB   = 0;
	localparam int          ST_BANK_LSB    = 5;
	localparam int          ST_READ_OK     = 9;
	localparam int          ST_ODT_TERM    = 10;
	localparam int          ERR_ILLEGAL    = 0;
	localparam int          ERR_CKE_SHORT  = 1;
	localparam int          ERR_EARLY_READ = 2;
	localparam int          ERR_BUSY_ENTRY = 3;

	// ****************************************
	// Commands as {ras_n, cas_n, we_n}
	// ****************************************
	localparam logic [2:0]  CMD_NOP   = 3'h7;
	localparam logic [2:0]  CMD_ACT   = 3'h3;
	localparam logic [2:0]  CMD_READ  = 3'h5;
	localparam logic [2:0]  CMD_WRITE = 3'h4;
	localparam logic [2:0]  CMD_PRE   = 3'h2;
	localparam logic [2:0]  CMD_REF   = 3'h1;
	localparam logic [2:0]  CMD_LM    = 3'h0;

	// ****************************************
	// Timing in link clocks
	// ****************************************
	localparam int          XSRD_CLOCKS    = 200;
	localparam int          CKE_MIN_CLOCKS = 3;
	localparam int          XARD_CLOCKS    = 2;
	localparam int          XARDS_CLOCKS   = 7;
	localparam int          BURST_CLOCKS   = 2;

	typedef enum logic [4:0] {
		ST_IDLE   = 5'b0_0001,
		ST_ACTIVE = 5'b0_0010,
		ST_APD    = 5'b0_0100,
		ST_PPD    = 5'b0_1000,
		ST_SREF   = 5'b1_0000
	} sckp_state_t;

endpackage

// ### logic/sckp_power_state.sv
// Clock-enable power-state control of the memory device
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
// Overview of operation
// - Action from state, CKE pair, command
// - Power-down edges with NOP only, kind
// - Self refresh entry by REFRESH, idle
// - No refresh performed during power-down
// - No termination in self refresh
// - Write auto precharge closes after recovery
// - Entry one clock after REF, ACT, PRE
// - Write recovery field in clocks, rounded up
// - Exit speed bit selects read delay, active power-down exit only
// - Buffers off in power-down, DLL frozen in precharge power-down only
module sckp_power_state
	import sckp_pkg::*;
#(
	parameter int XSRD   = XSRD_CLOCKS,
	parameter int XARD   = XARD_CLOCKS,
	parameter int XARDS  = XARDS_CLOCKS,
	parameter int BURST  = BURST_CLOCKS
) (
	input  wire logic        clock_i,
	input  wire logic        arst_n_i,
	input  wire logic        ck_i,
	input  wire logic        cke_i,
	input  wire logic        cs_n_i,
	input  wire logic        ras_n_i,
	input  wire logic        cas_n_i,
	input  wire logic        we_n_i,
	input  wire logic        a10_i,
	input  wire logic [1:0]  ba_i,
	input  wire logic        odt_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	output logic      [4:0]  state_o,
	output logic      [3:0]  banks_open_o,
	output logic             buffers_on_o,
	output logic             dll_frozen_o,
	output logic             odt_term_o,
	output logic             read_ok_o
);
	if (XSRD < 1 || XSRD > 255 || XARD < 1 || XARD > 255 ||
		XARDS < 1 || XARDS > 255 || BURST < 1 || BURST > 15) begin : g_chk
		$error("sckp_power_state: parameter out of range");
	end
	// ****************************************
	// State
	// ****************************************
	logic [9:0]  sync1, sync2, next_sync1, next_sync2;
	logic        ck_d, cke_prev, next_cke_prev;
	sckp_state_t state, next_state;
	logic [3:0]  banks, next_banks;
	logic [3:0]  busy_cnt, next_busy_cnt;
	logic [4:0]  wrap_cnt, next_wrap_cnt;
	logic [1:0]  wrap_ba, next_wrap_ba;
	logic [1:0]  cke_cnt, next_cke_cnt;
	logic [7:0]  ready_cnt, next_ready_cnt;
	logic [4:0]  ctrl, next_ctrl;
	logic [3:0]  err, next_err, err_set;
	logic [31:0] next_rdata;
	logic        next_buf, next_dll, next_odt, next_read_ok;
	logic        edge_ck, cke, cs_n, a10, odt, is_nop, entry;
	logic [2:0]  cmd;
	logic [1:0]  ba;
	assign edge_ck = sync2[9] & ~ck_d;
	assign cke     = sync2[8];
	assign cs_n    = sync2[7];
	assign cmd     = sync2[6:4];
	assign a10     = sync2[3];
	assign ba      = sync2[2:1];
	assign odt     = sync2[0];
	assign is_nop  = cs_n | (cmd == CMD_NOP);
	assign entry   = cke_prev & ~cke;
	// ****************************************
	// Next values
	// ****************************************
	always_comb begin
		next_sync1     = {ck_i, cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i,
			a10_i, ba_i, odt_i};
		next_sync2     = sync1;
		next_state     = state;
		next_banks     = banks;
		next_busy_cnt  = busy_cnt;
		next_wrap_cnt  = wrap_cnt;
		next_wrap_ba   = wrap_ba;
		next_cke_cnt   = cke_cnt;
		next_cke_prev  = cke_prev;
		next_ready_cnt = ready_cnt;
		err_set        = 4'h0;
		if (edge_ck) begin
			next_cke_prev = cke;
			if (busy_cnt != 4'h0)
				next_busy_cnt = busy_cnt - 4'h1;
			if (ready_cnt != 8'h00)
				next_ready_cnt = ready_cnt - 8'h01;
			if (wrap_cnt != 5'h00) begin
				next_wrap_cnt = wrap_cnt - 5'h01;
				if (wrap_cnt == 5'h01)
					next_banks[wrap_ba] = 1'b0;
			end
			if (cke != cke_prev) begin
				next_cke_cnt = 2'h1;
				if (cke_cnt < 2'(CKE_MIN_CLOCKS))
					err_set[ERR_CKE_SHORT] = 1'b1;
			end else if (cke_cnt < 2'(CKE_MIN_CLOCKS)) begin
				next_cke_cnt = cke_cnt + 2'h1;
			end
			unique case (state)
				ST_IDLE, ST_ACTIVE: begin
					if (entry) begin
						if (busy_cnt != 4'h0 || wrap_cnt > 5'h01)
							err_set[ERR_BUSY_ENTRY] = 1'b1;
						if (is_nop)
							next_state = (banks != 4'h0) ? ST_APD : ST_PPD;
						else if (cmd == CMD_REF && banks == 4'h0)
							next_state = ST_SREF;
						else
							err_set[ERR_ILLEGAL] = 1'b1;
					end else if (!cke) begin
						err_set[ERR_ILLEGAL] = 1'b1;
					end else begin
						unique case (cs_n ? CMD_NOP : cmd)
							CMD_ACT: next_banks[ba] = 1'b1;
							CMD_PRE: begin
								if (a10)
									next_banks = 4'h0;
								else
									next_banks[ba] = 1'b0;
							end
							CMD_READ: begin
								next_busy_cnt = 4'(BURST);
								if (ready_cnt != 8'h00)
									err_set[ERR_EARLY_READ] = 1'b1;
								if (a10) begin
									next_wrap_cnt = 5'(BURST);
									next_wrap_ba  = ba;
								end
							end
							CMD_WRITE: begin
								next_busy_cnt = 4'(BURST);
								if (a10) begin
									next_wrap_cnt = 5'(BURST) +
										{2'b00, ctrl[CTRL_WR_LSB+:3]};
									next_wrap_ba  = ba;
								end
							end
							CMD_LM:  next_busy_cnt = 4'(BURST);
							default: ;
						endcase
						next_state = (next_banks != 4'h0) ?
							ST_ACTIVE : ST_IDLE;
					end
				end
				ST_APD, ST_PPD: begin
					if (cke) begin
						if (!is_nop)
							err_set[ERR_ILLEGAL] = 1'b1;
						next_state = (banks != 4'h0) ? ST_ACTIVE : ST_IDLE;
						next_ready_cnt = (state == ST_APD &&
							ctrl[CTRL_SLOW_EXIT]) ? 8'(XARDS) : 8'(XARD);
					end
				end
				ST_SREF: begin
					if (cke) begin
						if (!is_nop)
							err_set[ERR_ILLEGAL] = 1'b1;
						next_state     = ST_IDLE;
						next_ready_cnt = 8'(XSRD);
					end
				end
			endcase
		end
		next_ctrl = ctrl;
		if (wr_i && addr_i == REG_CTRL)
			next_ctrl = wdata_i[4:0];
		next_err = err;
		if (wr_i && addr_i == REG_ERR)
			next_err = err & ~wdata_i[3:0];
		next_err = next_err | err_set;
		next_rdata = 32'h0000_0000;
		if (rd_i) begin
			unique case (addr_i)
				REG_CTRL:   next_rdata[4:0] = ctrl;
				REG_STATUS: begin
					next_rdata[ST_STATE_LSB+:5] = state;
					next_rdata[ST_BANK_LSB+:4]  = banks;
					next_rdata[ST_READ_OK]      = read_ok_o;
					next_rdata[ST_ODT_TERM]     = odt_term_o;
				end
				REG_ERR:    next_rdata[3:0] = err;
				default:    ;
			endcase
		end
		next_buf     = next_state inside {ST_IDLE, ST_ACTIVE};
		next_dll     = next_state == ST_PPD;
		next_odt     = odt & ctrl[CTRL_ODT_EN] & (next_state != ST_SREF);
		next_read_ok = next_ready_cnt == 8'h00;
	end
	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync1        <= 10'h000;
			sync2        <= 10'h000;
			ck_d         <= 1'b0;
			cke_prev     <= 1'b0;
			state        <= ST_IDLE;
			banks        <= 4'h0;
			busy_cnt     <= 4'h0;
			wrap_cnt     <= 5'h00;
			wrap_ba      <= 2'h0;
			cke_cnt      <= 2'(CKE_MIN_CLOCKS);
			ready_cnt    <= 8'h00;
			ctrl         <= CTRL_RESET;
			err          <= 4'h0;
			rdata_o      <= 32'h0000_0000;
			buffers_on_o <= 1'b1;
			dll_frozen_o <= 1'b0;
			odt_term_o   <= 1'b0;
			read_ok_o    <= 1'b1;
		end else begin
			sync1        <= next_sync1;
			sync2        <= next_sync2;
			ck_d         <= sync2[9];
			cke_prev     <= next_cke_prev;
			state        <= next_state;
			banks        <= next_banks;
			busy_cnt     <= next_busy_cnt;
			wrap_cnt     <= next_wrap_cnt;
			wrap_ba      <= next_wrap_ba;
			cke_cnt      <= next_cke_cnt;
			ready_cnt    <= next_ready_cnt;
			ctrl         <= next_ctrl;
			err          <= next_err;
			rdata_o      <= next_rdata;
			buffers_on_o <= next_buf;
			dll_frozen_o <= next_dll;
			odt_term_o   <= next_odt;
			read_ok_o    <= next_read_ok;
		end
	end
	assign state_o      = state;
	assign banks_open_o = banks;
	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	a_sref_odt_off: assert property (state == ST_SREF |-> !odt_term_o)
		else $error("termination on in self refresh");
	a_pd_buffers_off: assert property (
		state inside {ST_APD, ST_PPD, ST_SREF} |-> !buffers_on_o)
		else $error("buffers on in low power state");
	a_dll_freeze_ppd: assert property (
		dll_frozen_o == (state == ST_PPD))
		else $error("dll freeze does not match state");
	a_sref_from_idle: assert property (
		$rose(state == ST_SREF) |-> $past(banks) == 4'h0)
		else $error("self refresh entered with open bank");
	a_pd_kind: assert property (
		$rose(state == ST_APD) |-> banks != 4'h0)
		else $error("active power-down with no open bank");
	a_ppd_banks_hold: assert property (
		state == ST_PPD && $past(state) == ST_PPD |-> $stable(banks))
		else $error("bank state changed in power-down");
	a_sref_read_wait: assert property (
		$fell(state == ST_SREF) |-> !read_ok_o [*8])
		else $error("read allowed too soon after self refresh");
	a_illegal_flag: assert property (
		edge_ck && entry && state inside {ST_IDLE, ST_ACTIVE} &&
		!is_nop && !(cmd == CMD_REF && banks == 4'h0)
		|=> err[ERR_ILLEGAL])
		else $error("illegal entry not flagged");
	a_exit_nop_state: assert property (
		$fell(state == ST_APD) |-> state == ST_ACTIVE)
		else $error("active power-down left to wrong state");
	c_apd_entry:  cover property ($rose(state == ST_APD));
	c_sref_cycle: cover property ($fell(state == ST_SREF));
	c_ppd_exit:   cover property ($fell(state == ST_PPD));
	c_early_read: cover property ($rose(err[ERR_EARLY_READ]));
endmodule

// ### verif/sckp_ctrl_model.sv
// Controller model: link clock, CKE, commands and ODT
`timescale 1ns/10ps
module sckp_ctrl_model
	import sckp_pkg::*;
(
	input  wire logic       clock_i,
	output logic            ck_o,
	output logic            cke_o,
	output logic            cs_n_o,
	output logic      [2:0] cmd_o,
	output logic            a10_o,
	output logic      [1:0] ba_o,
	output logic            odt_o
);
	initial begin
		{ck_o, cke_o, cs_n_o, cmd_o, a10_o, ba_o, odt_o} = 10'h1f0;
		#3;
		forever #40 ck_o = ~ck_o;
	end

	// One command at one link edge, then deselect with toggled lines
	task automatic step(input logic k, input logic [2:0] c,
		input logic a, input logic [1:0] b);
		@(negedge ck_o);
		@(posedge clock_i);
		{cke_o, cs_n_o, cmd_o, a10_o, ba_o} <= {k, 1'b0, c, a, b};
		@(posedge ck_o);
		repeat (4) @(posedge clock_i);
		{cs_n_o, cmd_o, a10_o, ba_o} <= {1'b1, ~c, ~a, ~b};
		@(posedge clock_i);
		#1;
	endtask

	task automatic set_odt(input logic v);
		@(posedge clock_i);
		odt_o <= v;
	endtask
endmodule

// ### verif/sckp_power_state_bench.sv
// Self-checking bench of the power-state block
`timescale 1ns/10ps
module sckp_power_state_bench
	import sckp_pkg::*;
;
	logic        clock_i, arst_n_i, ck_i, cke_i, cs_n_i, a10_i, odt_i;
	logic        wr_i, rd_i, buffers_on_o, dll_frozen_o, odt_term_o;
	logic        read_ok_o;
	logic [2:0]  cmd;
	logic [1:0]  ba_i;
	logic [3:0]  addr_i, banks_open_o;
	logic [31:0] wdata_i, rdata_o;
	logic [4:0]  state_o;
	int          num_errors = 0;
	int          checks = 0;
	int          cycles = 0;

	sckp_ctrl_model sckp_ctrl_model_i (.clock_i, .ck_o(ck_i), .cke_o(cke_i),
		.cs_n_o(cs_n_i), .cmd_o(cmd), .a10_o(a10_i), .ba_o(ba_i), .odt_o(odt_i));
	sckp_power_state #(.XSRD(10)) sckp_power_state_i (.clock_i, .arst_n_i,
		.ck_i, .cke_i, .cs_n_i, .ras_n_i(cmd[2]), .cas_n_i(cmd[1]),
		.we_n_i(cmd[0]), .a10_i, .ba_i, .odt_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.rdata_o, .state_o, .banks_open_o, .buffers_on_o, .dll_frozen_o,
		.odt_term_o, .read_ok_o);

	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end

	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			num_errors++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		if (num_errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr_reg(logic [3:0] a, logic [31:0] d);
		@(posedge clock_i);
		{addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd_chk(string n, logic [3:0] a, logic [31:0] e);
		@(posedge clock_i);
		{addr_i, rd_i} <= {a, 1'b1};
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 chk(n, e, rdata_o);
	endtask

	task automatic go(logic k, logic [2:0] c, logic a, logic [1:0] b);
		sckp_ctrl_model_i.step(k, c, a, b);
	endtask

	task automatic edges(int n);
		repeat (n) @(posedge ck_i);
	endtask

	task automatic st(sckp_state_t s);
		chk("state", s, state_o);
		chk("buffers_on", s inside {ST_IDLE, ST_ACTIVE}, buffers_on_o);
		chk("dll_frozen", s == ST_PPD, dll_frozen_o);
	endtask

	task automatic t_reset();
		st(ST_IDLE);
		chk("read_ok", 1, read_ok_o);
		rd_chk("ctrl", REG_CTRL, 32'h0000_0004);
		rd_chk("status", REG_STATUS, 32'h0000_0201);
		wr_reg(4'hc, 32'hffff_ffff);
		rd_chk("unmapped", 4'hc, 32'h0000_0000);
		edges(3);
	endtask

	task automatic t_ppd();
		go(0, CMD_NOP, 0, 0);
		st(ST_PPD);
		go(0, CMD_ACT, 0, 1);
		st(ST_PPD);
		chk("banks", 0, banks_open_o);
		go(0, CMD_NOP, 0, 0);
		go(1, CMD_NOP, 0, 0);
		st(ST_IDLE);
		chk("read_ok", 0, read_ok_o);
		edges(4);
		chk("read_ok", 1, read_ok_o);
	endtask

	task automatic t_apd();
		wr_reg(REG_CTRL, 32'h0000_0006);
		go(1, CMD_ACT, 0, 1);
		chk("banks", 32'h0000_0002, banks_open_o);
		go(0, CMD_NOP, 0, 0);
		st(ST_APD);
		go(0, CMD_NOP, 0, 0);
		go(0, CMD_NOP, 0, 0);
		go(1, CMD_NOP, 0, 0);
		st(ST_ACTIVE);
		edges(4);
		chk("read_ok", 0, read_ok_o);
		edges(5);
		chk("read_ok", 1, read_ok_o);
	endtask

	task automatic t_sref();
		wr_reg(REG_CTRL, 32'h0000_0005);
		sckp_ctrl_model_i.set_odt(1'b1);
		go(1, CMD_PRE, 1, 0);
		st(ST_IDLE);
		chk("odt_term", 1, odt_term_o);
		go(1, CMD_LM, 0, 0);
		go(0, CMD_REF, 0, 0);
		st(ST_SREF);
		chk("odt_term", 0, odt_term_o);
		go(0, CMD_NOP, 0, 0);
		sckp_ctrl_model_i.set_odt(1'b0);
		go(0, CMD_NOP, 0, 0);
		go(1, CMD_NOP, 0, 0);
		st(ST_IDLE);
		edges(2);
		go(1, CMD_ACT, 0, 0);
		go(1, CMD_READ, 0, 0);
		edges(5);
		chk("read_ok", 0, read_ok_o);
		edges(6);
		chk("read_ok", 1, read_ok_o);
		rd_chk("err", REG_ERR, 32'h0000_000c);
		wr_reg(REG_ERR, 32'h0000_000c);
	endtask

	task automatic t_err();
		go(0, CMD_REF, 0, 0);
		st(ST_ACTIVE);
		go(1, CMD_NOP, 0, 0);
		rd_chk("err", REG_ERR, 32'h0000_0003);
		wr_reg(REG_ERR, 32'h0000_0003);
		edges(3);
		go(1, CMD_WRITE, 1, 0);
		edges(1);
		chk("banks", 32'h0000_0001, banks_open_o);
		edges(4);
		chk("banks", 0, banks_open_o);
		st(ST_IDLE);
		go(0, CMD_NOP, 0, 0);
		st(ST_PPD);
		rd_chk("err", REG_ERR, 32'h0000_0000);
	endtask

	initial begin
		{arst_n_i, addr_i, wdata_i, wr_i, rd_i} = '0;
		repeat (6) @(posedge clock_i);
		arst_n_i <= 1'b1;
		t_reset();
		t_ppd();
		t_apd();
		t_sref();
		t_err();
		report_and_stop();
	end
endmodule
